/* File: hw/scp_pkg.sv */
// Package with register map, field layout and types of the clock and power control block
package scp_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] SCP_SFR_CLK_PWR_ADDR = 8'hbe; // Clock and power control (SFR space)
	localparam logic [15:0] SCP_XREG_TRIM_ADDR = 16'h4002; // Oscillator trim (XREG space)
	localparam logic [15:0] SCP_XREG_CRYSTAL_ADDR = 16'h4016; // Crystal control (XREG space)

	// ----------------------------------------------------------------
	// Field positions of the clock and power control register
	// ----------------------------------------------------------------
	localparam int SCP_BIT_POWER_OFF = 7; // Power-off request
	localparam int SCP_BIT_RSVD = 6; // Reserved, reads zero
	localparam int SCP_BIT_BATTERY = 5; // Battery insertion flag
	localparam int SCP_BIT_TICK_CLR = 4; // Tick counter clear, write only
	localparam int SCP_BIT_PIN_FREEZE = 3; // GPIO hold
	localparam int SCP_DIV_LSB = 0; // Divide field low bit
	localparam int SCP_DIV_W = 3; // Divide field width
	localparam int SCP_DIV_CNT_W = 7; // Divider counter width, up to 128

	// ----------------------------------------------------------------
	// Field positions of the crystal control register
	// ----------------------------------------------------------------
	localparam int SCP_BIT_CRYSTAL_ENA = 0; // Crystal enable
	localparam int SCP_BIT_SMALL_CAP = 1; // Small load capacitance select

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0] SCP_TRIM_RST = 8'hff; // Trim resets to all ones
	localparam logic [7:0] SCP_BYTE_ZERO = 8'h00; // Zero byte, also unmapped read
	localparam logic [SCP_DIV_W-1:0] SCP_DIV_RST = 3'h0; // Divide by one after reset
	localparam int SCP_GPIO_W = 9; // Number of wake-capable GPIO inputs

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SCP_ST_RUN = 3'h1, // Normal operation
		SCP_ST_OFF = 3'h2, // Shut down, waiting for a button
		SCP_ST_WAKE = 3'h4 // Power-up and power-on reset requested
	} scp_pwr_state_type;

	// ----------------------------------------------------------------
	// Bus request carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr; // Write strobe, one cycle
		logic rd; // Read strobe, one cycle
		logic [7:0] addr; // SFR address
		logic [7:0] wdata; // Write data
	} scp_sfr_req_type;

	typedef struct packed {
		logic wr; // Write strobe, one cycle
		logic rd; // Read strobe, one cycle
		logic [15:0] addr; // XREG address
		logic [7:0] wdata; // Write data
	} scp_xreg_req_type;

endpackage

/* File: hw/scp_ctrl.sv */
// System clock divider, oscillator trim, shutdown and crystal control block
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - One divided clock for all digital blocks
// - Divide field selects divide by two-power
// - Power-off write shuts the chip down
// - GPIO falling edge wakes with power-on reset
// - Reserved bit six reads zero, ignores writes
// - Read-only flag marks battery-insertion power-up
// - Writing one clears the tick counter
// - Pin freeze holds GPIO, defers presses
// - Trim code resets to ones, tunes oscillator
// - Crystal enable bit, reset off
// - Crystal output routed to frequency counter
module scp_ctrl import scp_pkg::*; #(
	parameter int GPIO_W = SCP_GPIO_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire scp_sfr_req_type sfr_req,
	output logic [7:0] sfr_rdata,
	input wire scp_xreg_req_type xreg_req,
	output logic [7:0] xreg_rdata,
	input wire logic [GPIO_W-1:0] gpio_in,
	input wire logic battery_insert_in,
	input wire logic crystal_clk_in,
	output logic sys_clk_en,
	output logic power_off,
	output logic por_request,
	output logic gpio_hold,
	output logic tick_counter_clear,
	output logic [7:0] osc_trim_code,
	output logic crystal_osc_enable,
	output logic small_load_cap_select,
	output logic crystal_ref_clk
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic ctl_wr; // Write to clock and power control
	logic ctl_rd; // Read of clock and power control
	logic trim_wr; // Write to trim
	logic crystal_wr; // Write to crystal control
	logic gpio_fall; // Any GPIO went from high to low

	assign ctl_wr = sfr_req.wr && (sfr_req.addr == SCP_SFR_CLK_PWR_ADDR);
	assign ctl_rd = sfr_req.rd && (sfr_req.addr == SCP_SFR_CLK_PWR_ADDR);
	assign trim_wr = xreg_req.wr && (xreg_req.addr == SCP_XREG_TRIM_ADDR);
	assign crystal_wr = xreg_req.wr && (xreg_req.addr == SCP_XREG_CRYSTAL_ADDR);

	// ----------------------------------------------------------------
	// Register group
	// ----------------------------------------------------------------
	logic [SCP_DIV_W-1:0] div_field_q, div_field_d; // Divide as written
	logic freeze_q, freeze_d; // Pin freeze bit
	logic batt_q, batt_d; // Battery insertion flag
	logic boot_q, boot_d; // Flag caught after reset release
	logic [7:0] trim_q, trim_d; // Oscillator trim code
	logic crystal_ena_q, crystal_ena_d; // Crystal enable
	logic lowcap_q, lowcap_d; // Small load capacitance
	logic tick_clr_q, tick_clr_d; // Tick clear pulse
	logic [7:0] sfr_rdata_q, sfr_rdata_d; // SFR read answer
	logic [7:0] xreg_rdata_q, xreg_rdata_d; // XREG read answer
	logic [7:0] ctl_view; // Read image of clock and power control
	logic [7:0] crystal_view; // Read image of crystal control
	logic pwr_off_bit; // Power-off bit as seen by software

	// Next values of the software-visible registers
	always_comb begin
		div_field_d = div_field_q;
		freeze_d = freeze_q;
		trim_d = trim_q;
		crystal_ena_d = crystal_ena_q;
		lowcap_d = lowcap_q;
		batt_d = batt_q;
		boot_d = 1'b1;
		// Catch the power-up cause once after reset release
		if (!boot_q) begin
			batt_d = battery_insert_in;
		end
		// Writes; bits 6, 5 and 7 have no stored copy here
		if (ctl_wr) begin
			div_field_d = sfr_req.wdata[SCP_DIV_LSB +: SCP_DIV_W];
			freeze_d = sfr_req.wdata[SCP_BIT_PIN_FREEZE];
		end
		if (trim_wr) begin
			trim_d = xreg_req.wdata;
		end
		if (crystal_wr) begin
			crystal_ena_d = xreg_req.wdata[SCP_BIT_CRYSTAL_ENA];
			lowcap_d = xreg_req.wdata[SCP_BIT_SMALL_CAP];
		end
		// Tick clear is a one-cycle pulse on a write of one
		tick_clr_d = ctl_wr && sfr_req.wdata[SCP_BIT_TICK_CLR];
	end

	// Read images; write-only and reserved bits read zero
	always_comb begin
		ctl_view = SCP_BYTE_ZERO;
		ctl_view[SCP_BIT_POWER_OFF] = pwr_off_bit;
		ctl_view[SCP_BIT_RSVD] = 1'b0;
		ctl_view[SCP_BIT_BATTERY] = batt_q;
		ctl_view[SCP_BIT_PIN_FREEZE] = freeze_q;
		ctl_view[SCP_DIV_LSB +: SCP_DIV_W] = div_field_q;
		crystal_view = SCP_BYTE_ZERO;
		crystal_view[SCP_BIT_CRYSTAL_ENA] = crystal_ena_q;
		crystal_view[SCP_BIT_SMALL_CAP] = lowcap_q;
	end

	// Read answers, one cycle after the strobe, zero when unmapped
	always_comb begin
		sfr_rdata_d = SCP_BYTE_ZERO;
		xreg_rdata_d = SCP_BYTE_ZERO;
		if (ctl_rd) begin
			sfr_rdata_d = ctl_view;
		end
		if (xreg_req.rd && (xreg_req.addr == SCP_XREG_TRIM_ADDR)) begin
			xreg_rdata_d = trim_q;
		end else if (xreg_req.rd && (xreg_req.addr == SCP_XREG_CRYSTAL_ADDR)) begin
			xreg_rdata_d = crystal_view;
		end
	end

	// Register group flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_field_q <= SCP_DIV_RST;
			freeze_q <= 1'b0;
			batt_q <= 1'b0;
			boot_q <= 1'b0;
			trim_q <= SCP_TRIM_RST;
			crystal_ena_q <= 1'b0;
			lowcap_q <= 1'b0;
			tick_clr_q <= 1'b0;
			sfr_rdata_q <= SCP_BYTE_ZERO;
			xreg_rdata_q <= SCP_BYTE_ZERO;
		end else begin
			div_field_q <= div_field_d;
			freeze_q <= freeze_d;
			batt_q <= batt_d;
			boot_q <= boot_d;
			trim_q <= trim_d;
			crystal_ena_q <= crystal_ena_d;
			lowcap_q <= lowcap_d;
			tick_clr_q <= tick_clr_d;
			sfr_rdata_q <= sfr_rdata_d;
			xreg_rdata_q <= xreg_rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// System clock divider
	// ----------------------------------------------------------------
	logic [SCP_DIV_CNT_W-1:0] cnt_q, cnt_d; // Position in divided period
	logic [SCP_DIV_W-1:0] div_q, div_d; // Divide in force
	logic [SCP_DIV_CNT_W-1:0] term; // Last count of the period
	logic wrap; // End of a divided period
	logic clk_en_q, clk_en_d; // Divided clock enable pulse

	// Count to 2**div - 1; new divide taken only at the wrap
	always_comb begin
		term = SCP_DIV_CNT_W'((8'h01 << div_q) - 8'h01);
		wrap = (cnt_q == term);
		cnt_d = wrap ? '0 : SCP_DIV_CNT_W'(cnt_q + 1'b1);
		div_d = wrap ? div_field_q : div_q;
		clk_en_d = wrap;
	end

	// Divider flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			div_q <= SCP_DIV_RST;
			clk_en_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			div_q <= div_d;
			clk_en_q <= clk_en_d;
		end
	end

	// ----------------------------------------------------------------
	// Shutdown and wake
	// ----------------------------------------------------------------
	scp_pwr_state_type state_q, state_d; // Power state
	logic [GPIO_W-1:0] gpio_prev_q; // GPIO one cycle ago
	logic pending_q, pending_d; // Button press deferred by pin freeze
	logic pwr_off_q, pwr_off_d; // Shutdown output
	logic por_q, por_d; // Power-on reset request
	logic crystal_ref_q, crystal_ref_d; // Gated crystal clock to counter

	assign gpio_fall = |(gpio_prev_q & ~gpio_in);
	assign pwr_off_bit = (state_q != SCP_ST_RUN);

	// Power state transitions
	always_comb begin
		state_d = state_q;
		pending_d = pending_q;
		case (state_q)
			SCP_ST_RUN: begin
				// Presses while frozen wait for shutdown to finish
				if (freeze_q && gpio_fall) begin
					pending_d = 1'b1;
				end
				if (ctl_wr && sfr_req.wdata[SCP_BIT_POWER_OFF]) begin
					state_d = SCP_ST_OFF;
				end
			end
			SCP_ST_OFF: begin
				// Only a falling edge, now or deferred, wakes the chip
				if (gpio_fall || pending_q) begin
					state_d = SCP_ST_WAKE;
					pending_d = 1'b0;
				end
			end
			SCP_ST_WAKE: begin
				// Held until the power-on reset clears the block
				state_d = SCP_ST_WAKE;
			end
			default: begin
				state_d = SCP_ST_RUN;
			end
		endcase
		pwr_off_d = (state_d == SCP_ST_OFF) || (state_d == SCP_ST_WAKE);
		por_d = (state_d == SCP_ST_WAKE);
		crystal_ref_d = crystal_ena_q && crystal_clk_in;
	end

	// Power flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SCP_ST_RUN;
			gpio_prev_q <= '0;
			pending_q <= 1'b0;
			pwr_off_q <= 1'b0;
			por_q <= 1'b0;
			crystal_ref_q <= 1'b0;
		end else begin
			state_q <= state_d;
			gpio_prev_q <= gpio_in;
			pending_q <= pending_d;
			pwr_off_q <= pwr_off_d;
			por_q <= por_d;
			crystal_ref_q <= crystal_ref_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sfr_rdata = sfr_rdata_q;
	assign xreg_rdata = xreg_rdata_q;
	assign sys_clk_en = clk_en_q;
	assign power_off = pwr_off_q;
	assign por_request = por_q;
	assign gpio_hold = freeze_q;
	assign tick_counter_clear = tick_clr_q;
	assign osc_trim_code = trim_q;
	assign crystal_osc_enable = crystal_ena_q;
	assign small_load_cap_select = lowcap_q;
	assign crystal_ref_clk = crystal_ref_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence seq_off_req;
		state_q == SCP_ST_RUN && ctl_wr && sfr_req.wdata[SCP_BIT_POWER_OFF];
	endsequence

	sequence seq_wake_edge;
		state_q == SCP_ST_OFF && gpio_fall;
	endsequence

	AST_CLK_PULSE: assert property (wrap |=> sys_clk_en && cnt_q == '0)
		else $error("Divided clock pulse missing after wrap");
	AST_DIV_TWO: assert property (wrap && div_field_q == 3'h1 && div_q == 3'h1
		|=> sys_clk_en ##1 !sys_clk_en ##1 sys_clk_en)
		else $error("Divide by two period wrong");
	AST_DIV_BOUNDARY: assert property (div_q != $past(div_q) |-> $past(wrap))
		else $error("Divide changed inside a period");
	AST_SHUTDOWN: assert property (seq_off_req |=> power_off && !por_request)
		else $error("Power-off write did not shut down");
	AST_WAKE: assert property (seq_wake_edge |=> por_request ##1 por_request)
		else $error("Wake edge did not request power-on reset");
	AST_NO_SPURIOUS_WAKE: assert property ($rose(por_request) |-> $past(state_q == SCP_ST_OFF))
		else $error("Reset request outside shutdown");
	AST_RSVD_ZERO: assert property (sfr_rdata[SCP_BIT_RSVD] == 1'b0 && sfr_rdata[SCP_BIT_TICK_CLR] == 1'b0)
		else $error("Reserved or write-only bit read nonzero");
	AST_BATT_STABLE: assert property (boot_q |=> batt_q == $past(batt_q))
		else $error("Battery flag changed after power-up");
	AST_TICK_CLR: assert property (ctl_wr && sfr_req.wdata[SCP_BIT_TICK_CLR]
		|=> tick_counter_clear ##1 (!tick_counter_clear || ctl_wr))
		else $error("Tick clear pulse wrong");
	AST_DEFER: assert property (seq_off_req ##0 (freeze_q && gpio_fall)
		|=> pending_q ##1 por_request)
		else $error("Deferred press not kept across shutdown");
	AST_TRIM: assert property (trim_wr |=> osc_trim_code == $past(xreg_req.wdata))
		else $error("Trim write not stored");
	AST_CRYSTAL_REF: assert property (!crystal_osc_enable |=> !crystal_ref_clk)
		else $error("Crystal clock passed while disabled");

endmodule
`default_nettype wire

/* File: verif/test_scp_ctrl.sv */
// Self-checking testbench for the clock and power control block
`timescale 1ns/10ps
`default_nettype none

module test_scp_ctrl;
	import scp_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic mclk = 1'b0; // 100 MHz bench clock
	logic rst_n = 1'b0; // Async reset, active low
	scp_sfr_req_type sfr_req = '0; // SFR request
	scp_xreg_req_type xreg_req = '0; // XREG request
	logic [SCP_GPIO_W-1:0] gpio_in = '1; // Buttons idle high
	logic battery_insert_in = 1'b1; // Power-up cause
	logic crystal_clk_in = 1'b0; // Crystal output
	logic [7:0] sfr_rdata, xreg_rdata, osc_trim_code, q;
	logic sys_clk_en, power_off, por_request, gpio_hold, tick_counter_clear;
	logic crystal_osc_enable, small_load_cap_select, crystal_ref_clk;
	int n_errors = 0; // Mismatches seen
	int samples_checked = 0; // Comparisons made
	int cyc = 0; // Cycle count for hang guard

	always #5 mclk = ~mclk;

	scp_ctrl scp_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .xreg_req(xreg_req), .xreg_rdata(xreg_rdata),
		.gpio_in(gpio_in), .battery_insert_in(battery_insert_in),
		.crystal_clk_in(crystal_clk_in),
		.sys_clk_en(sys_clk_en), .power_off(power_off), .por_request(por_request),
		.gpio_hold(gpio_hold), .tick_counter_clear(tick_counter_clear),
		.osc_trim_code(osc_trim_code), .crystal_osc_enable(crystal_osc_enable),
		.small_load_cap_select(small_load_cap_select), .crystal_ref_clk(crystal_ref_clk));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One byte access; returns just after the taking edge
	task automatic acc(input bit x, input bit w, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		if (x) xreg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		else sfr_req <= '{wr: w, rd: !w, addr: a[7:0], wdata: d};
		@(posedge mclk);
		sfr_req <= '0;
		xreg_req <= '0;
		#1 q = x ? xreg_rdata : sfr_rdata;
	endtask

	task automatic do_reset(input logic batt);
		@(posedge mclk);
		rst_n <= 1'b0;
		battery_insert_in <= batt;
		gpio_in <= '1;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
	endtask

	task automatic final_report;
		$display("Counts: %0d checked, %0d errors", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		chk(osc_trim_code, 8'hff);
		acc(1, 0, 16'h4002, 8'h00);
		chk(q, 8'hff);
		acc(1, 0, 16'h4016, 8'h00);
		chk(q, 8'h00);
		acc(0, 0, 16'h00be, 8'h00);
		chk(q, 8'h20);
		acc(1, 1, 16'h4002, 8'h5a);
		chk(osc_trim_code, 8'h5a);
		acc(1, 1, 16'h4003, 8'h11);
		acc(1, 0, 16'h4003, 8'h00);
		chk(q, 8'h00);
		acc(1, 0, 16'h4002, 8'h00);
		chk(q, 8'h5a);
		acc(0, 0, 16'h0055, 8'h00);
		chk(q, 8'h00);
		$display("Test registers done");
	endtask

	task automatic t_tick;
		acc(0, 1, 16'h00be, 8'h77);
		chk(tick_counter_clear, 1'b1);
		@(posedge mclk);
		#1 chk(tick_counter_clear, 1'b0);
		acc(0, 0, 16'h00be, 8'h00);
		chk(q, 8'h27);
		$display("Test tick clear done");
	endtask

	task automatic t_div;
		int n;
		for (int i = 0; i < 8; i++) begin
			acc(0, 1, 16'h00be, 8'(i));
			repeat (3) begin
				n = 0;
				do begin
					@(posedge mclk);
					#1 n++;
				end while (sys_clk_en !== 1'b1 && n < 300);
			end
			chk(8'(n), 8'(1 << i));
		end
		$display("Test divider done");
	endtask

	task automatic t_crystal;
		acc(1, 1, 16'h4016, 8'hff);
		chk({crystal_osc_enable, small_load_cap_select}, 8'h03);
		acc(1, 0, 16'h4016, 8'h00);
		chk(q, 8'h03);
		@(posedge mclk);
		crystal_clk_in <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk(crystal_ref_clk, 1'b1);
		@(posedge mclk);
		crystal_clk_in <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk(crystal_ref_clk, 1'b0);
		@(posedge mclk);
		crystal_clk_in <= 1'b1;
		acc(1, 1, 16'h4016, 8'h00);
		repeat (4) @(posedge mclk);
		#1 chk(crystal_ref_clk, 1'b0);
		$display("Test crystal done");
	endtask

	task automatic t_hold_off;
		acc(0, 1, 16'h00be, 8'h08);
		chk(gpio_hold, 1'b1);
		@(posedge mclk);
		gpio_in <= 9'h1fe;
		repeat (3) @(posedge mclk);
		#1 chk({power_off, por_request}, 8'h00);
		// Release, then press again on the edge that takes the power-off write
		@(posedge mclk);
		gpio_in <= '1;
		@(posedge mclk);
		gpio_in <= 9'h1fe;
		sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'hbe, wdata: 8'h88};
		@(posedge mclk);
		sfr_req <= '0;
		#1 chk({power_off, por_request}, 8'h02);
		repeat (2) @(posedge mclk);
		#1 chk(por_request, 1'b1);
		acc(0, 1, 16'h00be, 8'h00);
		chk(power_off, 1'b1);
		acc(0, 0, 16'h00be, 8'h00);
		chk(q, 8'ha0);
		$display("Test hold and shutdown done");
	endtask

	task automatic t_wake;
		acc(0, 0, 16'h00be, 8'h00);
		chk(q, 8'h00);
		@(posedge mclk);
		gpio_in <= 9'h0ff;
		repeat (2) @(posedge mclk);
		gpio_in <= '1;
		acc(0, 1, 16'h00be, 8'h80);
		repeat (5) @(posedge mclk);
		#1 chk({power_off, por_request}, 8'h02);
		@(posedge mclk);
		gpio_in <= 9'h0ff;
		repeat (2) @(posedge mclk);
		#1 chk(por_request, 1'b1);
		$display("Test wake done");
	endtask

	// ----------------------------------------------------------------
	// Hang guard and main sequence
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		do_reset(1'b1);
		@(posedge mclk);
		#1 chk(sys_clk_en, 1'b1);
		t_regs();
		t_tick();
		t_div();
		t_crystal();
		t_hold_off();
		do_reset(1'b0);
		t_wake();
		final_report();
	end
endmodule

`default_nettype wire
